// ==== dsps_pkg.sv ====
// Package of constants and types for the debug and scan port select block.
package dsps_pkg;
  // ---------------------------------------------------------------------------
  // Debug resources
  // ---------------------------------------------------------------------------
  localparam int DSPS_NUM_BKPT = 4;
  localparam int DSPS_NUM_WATCH = 2;
  localparam int DSPS_TRACE_DEPTH = 16;
  localparam int DSPS_PC_W = 32;
  localparam int DSPS_BORROW_PINS = 4;
  // ---------------------------------------------------------------------------
  // Pin map of the borrowed port pins
  // ---------------------------------------------------------------------------
  localparam int DSPS_PIN_TCK = 0;
  localparam int DSPS_PIN_TMS = 1;
  localparam int DSPS_PIN_TDI = 2;
  localparam int DSPS_PIN_TDO = 3;
  localparam logic [3:0] DSPS_SCAN_OE = 4'h8;
  localparam logic [1:0] DSPS_SYNC_RST = 2'h0;
  typedef enum logic [1:0] {DSPS_MODE_RESET, DSPS_MODE_DEBUG, DSPS_MODE_SCAN} dsps_mode_t;
endpackage

// ==== dsps_sync.sv ====
// Two flip-flop level synchroniser.
module dsps_sync
  import dsps_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic [1:0] sync_r;
  logic [1:0] sync_nxt;
  // ---------------------------------------------------------------------------
  // Synchroniser stages
  // ---------------------------------------------------------------------------
  always_comb
  begin
    sync_nxt = {sync_r[0], d};
  end
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sync_r <= DSPS_SYNC_RST;
    else
      sync_r <= sync_nxt;
  end
  assign q = sync_r[1];
endmodule

// ==== dsps_tester.sv ====
// Model of the external probe and boundary scan tester at the far side.
module dsps_tester
(
  input wire logic clk,
  output logic reset_pin_n,
  output logic scan_clk,
  output logic scan_trst_n,
  output logic [2:0] scan_pins,
  output logic boundary_tdo
);
  timeunit 1ns;
  timeprecision 1ps;
  parameter int POWER_UP_WAIT_NS = 250000;
  // ---------------------------------------------------------------------------
  // Power-up state and entry and exit sequences
  // ---------------------------------------------------------------------------
  initial
  begin
    reset_pin_n = 1'h1;
    scan_clk = 1'h0;
    scan_trst_n = 1'h1;
    scan_pins = 3'h0;
    boundary_tdo = 1'h0;
  end
  // The model holds no program, so the flash counts as already erased.
  task automatic enter_scan();
    #POWER_UP_WAIT_NS;
    @(negedge clk);
    reset_pin_n = 1'h0;
  endtask
  // The link clock only runs inside a frame; the chain output is inverted after it.
  task automatic frame(input logic [2:0] pins, input logic tdo);
    @(negedge clk);
    scan_pins = pins;
    boundary_tdo = tdo;
    #1.3;
    repeat (4)
    begin
      #7.5 scan_clk = 1'h1;
      #7.5 scan_clk = 1'h0;
    end
    #1 boundary_tdo = ~tdo;
  endtask
  task automatic exit_scan();
    @(negedge clk);
    scan_trst_n = 1'h0;
    repeat (4) @(negedge clk);
    reset_pin_n = 1'h1;
    repeat (4) @(negedge clk);
    scan_trst_n = 1'h1;
  endtask
endmodule

// ==== dsps_top.sv ====
// Debug and boundary scan port select with breakpoint, watchpoint and trace logic.
// -----------------------------------------------------------------------------
// Summary of operation
// - Reset pin low selects boundary scan; reset pin high selects serial wire debug.
// - Serial wire debug port stays disabled while the device is in reset.
// - Scan mode routes scan signals onto port pins zero through three by hardware.
// - Scan interface gives boundary scan only, never processor debug access.
// - Debug logic provides four breakpoint and two watchpoint comparators.
// - An on-chip instruction trace buffer is part of the debug resources.
// -----------------------------------------------------------------------------
module dsps_top
  import dsps_pkg::*;
#(
  parameter int NUM_BKPT = DSPS_NUM_BKPT,
  parameter int NUM_WATCH = DSPS_NUM_WATCH,
  parameter int TRACE_DEPTH = DSPS_TRACE_DEPTH
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic reset_pin_n,
  input wire logic scan_clk,
  input wire logic scan_trst_n,
  input wire logic [3:0] port0_pin_in,
  input wire logic [3:0] gpio_out,
  input wire logic [3:0] gpio_oe,
  input wire logic boundary_tdo,
  input wire logic [NUM_BKPT*DSPS_PC_W-1:0] bkpt_addr,
  input wire logic [NUM_BKPT-1:0] bkpt_en,
  input wire logic [NUM_WATCH*DSPS_PC_W-1:0] watch_addr,
  input wire logic [NUM_WATCH-1:0] watch_en,
  input wire logic [DSPS_PC_W-1:0] cpu_pc,
  input wire logic cpu_pc_valid,
  input wire logic [DSPS_PC_W-1:0] cpu_data_addr,
  input wire logic cpu_data_valid,
  input wire logic [$clog2(TRACE_DEPTH)-1:0] trace_rd_idx,
  output logic [3:0] port0_pin_out,
  output logic [3:0] port0_pin_oe,
  output logic [3:0] gpio_in,
  output logic scan_active,
  output logic swd_enable,
  output logic scan_tck,
  output logic scan_tms,
  output logic scan_tdi,
  output logic bkpt_hit,
  output logic watch_hit,
  output logic [DSPS_PC_W-1:0] trace_rd_data
);
  localparam int TW = $clog2(TRACE_DEPTH);
  logic rst_lvl;
  logic trst_lvl;
  dsps_mode_t mode_r;
  dsps_mode_t mode_nxt;
  logic [3:0] pin_out_r;
  logic [3:0] pin_out_nxt;
  logic [3:0] pin_oe_r;
  logic [3:0] pin_oe_nxt;
  logic [3:0] pin_in_s1_r;
  logic [3:0] pin_in_s2_r;
  logic [3:0] gpio_in_r;
  logic [3:0] gpio_in_nxt;
  logic [2:0] scan_sig_r;
  logic [2:0] scan_sig_nxt;
  logic scan_act_r;
  logic swd_en_r;
  logic tdo_r;
  logic tdo_nxt;
  logic tdo_lvl;
  logic sync_ok;
  logic bkpt_hit_r;
  logic bkpt_hit_nxt;
  logic watch_hit_r;
  logic watch_hit_nxt;
  logic [NUM_BKPT-1:0] bkpt_match;
  logic [NUM_WATCH-1:0] watch_match;
  logic [DSPS_PC_W-1:0] trace_mem_r [TRACE_DEPTH];
  logic [TW-1:0] trace_wr_r;
  logic [TW-1:0] trace_wr_nxt;
  logic [DSPS_PC_W-1:0] trace_rd_r;
  logic [DSPS_PC_W-1:0] trace_rd_nxt;
  // ---------------------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------------------
  dsps_sync u_rst_sync (.clk(core_clk), .rst_n(resetn), .d(reset_pin_n), .q(rst_lvl));
  dsps_sync u_trst_sync (.clk(core_clk), .rst_n(resetn), .d(scan_trst_n), .q(trst_lvl));
  // A constant one through two stages marks valid pin levels; reset zeros look like scan.
  dsps_sync u_ready_sync (.clk(core_clk), .rst_n(resetn), .d(1'b1), .q(sync_ok));
  // The chain output comes from the link clock domain and is resynchronised here.
  dsps_sync u_tdo_sync (.clk(core_clk), .rst_n(resetn), .d(tdo_r), .q(tdo_lvl));
  // ---------------------------------------------------------------------------
  // Mode select
  // ---------------------------------------------------------------------------
  always_comb
  begin
    mode_nxt = mode_r;
    unique case (mode_r)
      DSPS_MODE_RESET:
        if (sync_ok && rst_lvl)
          mode_nxt = DSPS_MODE_DEBUG;
        else if (sync_ok)
          mode_nxt = DSPS_MODE_SCAN;
      DSPS_MODE_DEBUG:
        if (!rst_lvl)
          mode_nxt = DSPS_MODE_SCAN;
      DSPS_MODE_SCAN:
        // The reset pin high leaves scan for debug, whatever the level of test reset.
        if (rst_lvl && !trst_lvl)
          mode_nxt = DSPS_MODE_DEBUG;
        else if (rst_lvl)
          mode_nxt = DSPS_MODE_DEBUG;
      default:
        mode_nxt = DSPS_MODE_RESET;
    endcase
  end
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      mode_r <= DSPS_MODE_RESET;
      scan_act_r <= 1'b0;
      swd_en_r <= 1'b0;
    end
    else
    begin
      mode_r <= mode_nxt;
      scan_act_r <= (mode_nxt == DSPS_MODE_SCAN);
      swd_en_r <= (mode_nxt == DSPS_MODE_DEBUG);
    end
  end
  // ---------------------------------------------------------------------------
  // Scan side signals, sampled on the scan clock
  // ---------------------------------------------------------------------------
  always_comb
  begin
    tdo_nxt = boundary_tdo;
  end
  always_ff @(negedge scan_clk or negedge resetn)
  begin
    if (!resetn)
      tdo_r <= 1'b0;
    else
      tdo_r <= tdo_nxt;
  end
  // ---------------------------------------------------------------------------
  // Borrowed pin routing
  // ---------------------------------------------------------------------------
  always_comb
  begin
    if (mode_nxt == DSPS_MODE_SCAN)
    begin
      pin_out_nxt = '0;
      pin_out_nxt[DSPS_PIN_TDO] = tdo_lvl;
      pin_oe_nxt = DSPS_SCAN_OE;
      gpio_in_nxt = '0;
      scan_sig_nxt = {pin_in_s2_r[DSPS_PIN_TDI], pin_in_s2_r[DSPS_PIN_TMS],
                      pin_in_s2_r[DSPS_PIN_TCK]};
    end
    else
    begin
      pin_out_nxt = gpio_out;
      pin_oe_nxt = gpio_oe;
      gpio_in_nxt = pin_in_s2_r;
      scan_sig_nxt = '0;
    end
  end
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      pin_out_r <= '0;
      pin_oe_r <= '0;
      pin_in_s1_r <= '0;
      pin_in_s2_r <= '0;
      gpio_in_r <= '0;
      scan_sig_r <= '0;
    end
    else
    begin
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
      pin_in_s1_r <= port0_pin_in;
      pin_in_s2_r <= pin_in_s1_r;
      gpio_in_r <= gpio_in_nxt;
      scan_sig_r <= scan_sig_nxt;
    end
  end
  // ---------------------------------------------------------------------------
  // Breakpoint and watchpoint comparators
  // ---------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_BKPT; gi++)
    begin : g_bkpt
      assign bkpt_match[gi] = bkpt_en[gi] && cpu_pc_valid &&
                              (bkpt_addr[gi*DSPS_PC_W +: DSPS_PC_W] == cpu_pc);
    end
    for (gi = 0; gi < NUM_WATCH; gi++)
    begin : g_watch
      assign watch_match[gi] = watch_en[gi] && cpu_data_valid &&
                               (watch_addr[gi*DSPS_PC_W +: DSPS_PC_W] == cpu_data_addr);
    end
  endgenerate
  always_comb
  begin
    // Comparators only fire in debug mode, so the scan port never halts the core.
    bkpt_hit_nxt = swd_en_r && (|bkpt_match);
    watch_hit_nxt = swd_en_r && (|watch_match);
  end
  // ---------------------------------------------------------------------------
  // Instruction trace buffer
  // ---------------------------------------------------------------------------
  always_comb
  begin
    trace_wr_nxt = trace_wr_r;
    if (swd_en_r && cpu_pc_valid)
      trace_wr_nxt = trace_wr_r + 1'b1;
    trace_rd_nxt = trace_mem_r[trace_rd_idx];
  end
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      bkpt_hit_r <= 1'b0;
      watch_hit_r <= 1'b0;
      trace_wr_r <= '0;
      trace_rd_r <= '0;
    end
    else
    begin
      bkpt_hit_r <= bkpt_hit_nxt;
      watch_hit_r <= watch_hit_nxt;
      trace_wr_r <= trace_wr_nxt;
      trace_rd_r <= trace_rd_nxt;
    end
  end
  // Trace storage has no reset; entries are only valid once written.
  always_ff @(posedge core_clk)
  begin
    if (swd_en_r && cpu_pc_valid)
      trace_mem_r[trace_wr_r] <= cpu_pc;
  end
  assign port0_pin_out = pin_out_r;
  assign port0_pin_oe = pin_oe_r;
  assign gpio_in = gpio_in_r;
  assign scan_active = scan_act_r;
  assign swd_enable = swd_en_r;
  assign scan_tck = scan_sig_r[0];
  assign scan_tms = scan_sig_r[1];
  assign scan_tdi = scan_sig_r[2];
  assign bkpt_hit = bkpt_hit_r;
  assign watch_hit = watch_hit_r;
  assign trace_rd_data = trace_rd_r;
  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  scan_low_sel_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (!rst_lvl && mode_r != DSPS_MODE_RESET) |=> scan_active)
    else $error("Scan mode not entered with reset pin low.");
  debug_high_sel_a: assert property (@(posedge core_clk) disable iff (!resetn)
    rst_lvl ##1 rst_lvl |=> swd_enable)
    else $error("Debug mode not entered with reset pin high.");
  swd_off_reset_a: assert property (@(posedge core_clk) disable iff (!resetn)
    $rose(resetn) |-> !swd_enable)
    else $error("Debug port enabled straight out of reset.");
  scan_pin_oe_a: assert property (@(posedge core_clk) disable iff (!resetn)
    scan_active |-> port0_pin_oe == DSPS_SCAN_OE)
    else $error("Borrowed pins not routed to scan.");
  scan_excl_a: assert property (@(posedge core_clk) disable iff (!resetn)
    !(scan_active && swd_enable))
    else $error("Scan and debug active together.");
  scan_no_bkpt_a: assert property (@(posedge core_clk) disable iff (!resetn)
    scan_active ##1 scan_active |-> !bkpt_hit && !watch_hit)
    else $error("Debug event raised in scan mode.");
  bkpt_fire_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (swd_enable && bkpt_en[0] && cpu_pc_valid && bkpt_addr[DSPS_PC_W-1:0] == cpu_pc)
    |=> bkpt_hit)
    else $error("Breakpoint comparator missed a match.");
  trace_adv_a: assert property (@(posedge core_clk) disable iff (!resetn)
    (swd_enable && cpu_pc_valid) |=> trace_wr_r == $past(trace_wr_r) + 1'b1)
    else $error("Trace write index did not advance.");
  pin_restore_a: assert property (@(posedge core_clk) disable iff (!resetn)
    $fell(scan_active) |-> port0_pin_oe == $past(gpio_oe))
    else $error("Borrowed pins not restored after scan.");
endmodule

// ==== dsps_top_bench.sv ====
// Self-checking bench for the debug and scan port select block.
module dsps_top_bench;
  import dsps_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [31:0] pc; logic [31:0] da; logic [3:0] ben; logic eb; logic ew;} dsps_row_t;
  logic core_clk, resetn, reset_pin_n, scan_clk, scan_trst_n, boundary_tdo;
  logic [2:0] scan_pins;
  logic [3:0] pin_w, gpio_out, gpio_oe, bkpt_en, port0_pin_out, port0_pin_oe, gpio_in;
  logic [127:0] bkpt_addr;
  logic [63:0] watch_addr;
  logic [1:0] watch_en;
  logic [31:0] cpu_pc, cpu_data_addr, trace_rd_data;
  logic cpu_pc_valid, cpu_data_valid, scan_active, swd_enable, scan_tck, scan_tms, scan_tdi;
  logic bkpt_hit, watch_hit;
  logic [3:0] trace_rd_idx;
  int err_total = 0;
  int samples_checked = 0;
  dsps_row_t rows [8] = '{
    '{32'h1000, 32'h30000000, 4'hF, 1'h1, 1'h0}, '{32'h1010, 32'h30000000, 4'hF, 1'h1, 1'h0},
    '{32'h1020, 32'h30000000, 4'hF, 1'h1, 1'h0}, '{32'h1030, 32'h30000000, 4'hF, 1'h1, 1'h0},
    '{32'h1040, 32'h20000000, 4'hF, 1'h0, 1'h1}, '{32'h1050, 32'h20000004, 4'hF, 1'h0, 1'h1},
    '{32'h1060, 32'h20000008, 4'hF, 1'h0, 1'h0}, '{32'h1000, 32'h30000000, 4'hE, 1'h0, 1'h0}};
  // Pin 3 shows the block's drive when enabled, else the tester's weak high.
  assign pin_w = (port0_pin_oe & port0_pin_out) | (~port0_pin_oe & {1'h1, scan_pins});
  dsps_top dut_u (.core_clk(core_clk), .resetn(resetn), .reset_pin_n(reset_pin_n),
    .scan_clk(scan_clk), .scan_trst_n(scan_trst_n), .port0_pin_in(pin_w), .gpio_out(gpio_out),
    .gpio_oe(gpio_oe), .boundary_tdo(boundary_tdo), .bkpt_addr(bkpt_addr), .bkpt_en(bkpt_en),
    .watch_addr(watch_addr), .watch_en(watch_en), .cpu_pc(cpu_pc), .cpu_pc_valid(cpu_pc_valid),
    .cpu_data_addr(cpu_data_addr), .cpu_data_valid(cpu_data_valid), .trace_rd_idx(trace_rd_idx),
    .port0_pin_out(port0_pin_out), .port0_pin_oe(port0_pin_oe), .gpio_in(gpio_in),
    .scan_active(scan_active), .swd_enable(swd_enable), .scan_tck(scan_tck),
    .scan_tms(scan_tms), .scan_tdi(scan_tdi), .bkpt_hit(bkpt_hit), .watch_hit(watch_hit),
    .trace_rd_data(trace_rd_data));
  dsps_tester tester_u (.clk(core_clk), .reset_pin_n(reset_pin_n), .scan_clk(scan_clk),
    .scan_trst_n(scan_trst_n), .scan_pins(scan_pins), .boundary_tdo(boundary_tdo));
  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic results();
    $display("checked %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      $display("BAD t=%0t %s got %h want %h", $time, msg, got, exp);
      err_total++;
    end
  endtask
  // A bounded wait keeps a stuck mode from hanging the run.
  task automatic wait_for(input logic want_scan);
    int n;
    n = 0;
    while ((want_scan ? scan_active : swd_enable) !== 1'h1)
    begin
      @(negedge core_clk);
      n++;
      if (n > 40)
      begin
        $display("BAD t=%0t mode wait ran out", $time);
        err_total++;
        results();
      end
    end
    repeat (4) @(negedge core_clk);
  endtask
  // The hit is looked for over two cycles, since it is a one-cycle pulse.
  // Outside debug mode no hit may show at all.
  task automatic pulse(input dsps_row_t r, input logic dbg = 1'h1);
    logic b, w;
    @(negedge core_clk);
    bkpt_en = r.ben;
    cpu_pc = r.pc;
    cpu_data_addr = r.da;
    cpu_pc_valid = 1'h1;
    cpu_data_valid = 1'h1;
    @(negedge core_clk);
    b = bkpt_hit;
    w = watch_hit;
    cpu_pc_valid = 1'h0;
    cpu_data_valid = 1'h0;
    @(negedge core_clk);
    chk({31'h0, b | bkpt_hit}, {31'h0, r.eb & dbg}, "breakpoint hit");
    chk({31'h0, w | watch_hit}, {31'h0, r.ew & dbg}, "watchpoint hit");
  endtask
  // ---------------------------------------------------------------------------
  // Clock and main sequence
  // ---------------------------------------------------------------------------
  initial
  begin
    core_clk = 1'h0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial
  begin
    resetn = 1'h0;
    gpio_out = 4'hA;
    gpio_oe = 4'h5;
    bkpt_en = 4'hF;
    watch_en = 2'h3;
    bkpt_addr = {32'h1030, 32'h1020, 32'h1010, 32'h1000};
    watch_addr = {32'h20000004, 32'h20000000};
    cpu_pc = 32'h0;
    cpu_pc_valid = 1'h0;
    cpu_data_addr = 32'h0;
    cpu_data_valid = 1'h0;
    trace_rd_idx = 4'h0;
    repeat (20) @(negedge core_clk);
    chk({30'h0, swd_enable, scan_active}, 32'h0, "mode during reset");
    resetn = 1'h1;
    wait_for(1'h0);
    chk({31'h0, scan_active}, 32'h0, "scan with pin high");
    chk({24'h0, port0_pin_oe, port0_pin_out}, 32'h5A, "normal pin drive");
    chk({28'h0, gpio_in}, 32'h8, "normal pin input");
    $display("test reset and debug mode done");
    foreach (rows[i]) pulse(rows[i]);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge core_clk);
      trace_rd_idx = i[3:0];
      repeat (2) @(negedge core_clk);
      chk(trace_rd_data, rows[i].pc, "trace entry");
    end
    $display("test comparators and trace done");
    tester_u.enter_scan();
    wait_for(1'h1);
    chk({31'h0, swd_enable}, 32'h0, "debug open in scan");
    chk({24'h0, port0_pin_oe, gpio_in}, 32'h80, "scan pin takeover");
    tester_u.frame(3'h5, 1'h1);
    repeat (6) @(negedge core_clk);
    chk({28'h0, port0_pin_out[3], scan_tdi, scan_tms, scan_tck}, 32'hD, "scan route one");
    tester_u.frame(3'h2, 1'h0);
    repeat (6) @(negedge core_clk);
    chk({28'h0, port0_pin_out[3], scan_tdi, scan_tms, scan_tck}, 32'h2, "scan route two");
    pulse(rows[0], 1'h0);
    $display("test scan mode done");
    tester_u.exit_scan();
    wait_for(1'h0);
    chk({29'h0, scan_active, scan_tck, scan_tms}, 32'h0, "scan left");
    chk({24'h0, port0_pin_oe, port0_pin_out}, 32'h5A, "pins given back");
    pulse(rows[1]);
    $display("test scan exit done");
    @(negedge core_clk);
    resetn = 1'h0;
    repeat (3) @(negedge core_clk);
    chk({31'h0, swd_enable}, 32'h0, "debug open in reset");
    resetn = 1'h1;
    repeat (2) @(negedge core_clk);
    chk({30'h0, swd_enable, scan_active}, 32'h0, "mode settling");
    wait_for(1'h0);
    $display("test second reset done");
    results();
  end
endmodule
